// ===== core/tt_pkg.sv
// Shared constants and types for the timer-two flag and baud-select block.
package tt_pkg;

  // Byte offsets of the registers on the bus.
  localparam logic [7:0]  TT_CTRL_OFS   = 8'hC8;
  localparam logic [7:0]  TT_MODE_OFS   = 8'hCC;
  localparam logic [7:0]  TT_COUNT_OFS  = 8'hD0;
  localparam logic [7:0]  TT_RELOAD_OFS = 8'hD4;

  // Field positions in the timer_two_control register.
  localparam int          TT_BIT_OVF    = 7;
  localparam int          TT_BIT_EXT    = 6;
  localparam int          TT_BIT_RCLK   = 5;
  localparam int          TT_BIT_TX_CLOCK_SELECT   = 4;
  localparam int          TT_BIT_EXEN   = 3;
  localparam int          TT_BIT_RUN    = 2;
  localparam int          TT_BIT_CT     = 1;
  localparam int          TT_BIT_CP     = 0;

  // Field position in the timer_two_mode register.
  localparam int          TT_BIT_DOWN_COUNT_ENABLE   = 0;

  // Reset values and count limits.
  localparam logic [7:0]  TT_CTRL_RST   = 8'h00;
  localparam logic [0:0]  TT_MODE_RST   = 1'b0;
  localparam logic [15:0] TT_COUNT_RST  = 16'h0000;
  localparam logic [15:0] TT_COUNT_TOP  = 16'hFFFF;
  localparam logic [15:0] TT_COUNT_ONE  = 16'h0001;
  localparam logic [31:0] TT_RDATA_RST  = 32'h0000_0000;

  // Clock cycles per count in baud generation.
  localparam int          TT_BAUD_DIV   = 2;

  // Bit of the bus transfer type that is set for an active transfer.
  localparam int          TT_HTRANS_ACT = 1;

  // Data phase of the bus slave.
  typedef enum logic {
    TT_DP_IDLE,
    TT_DP_WRITE
  } tt_dphase_type;

endpackage

// ===== core/tt_fall_det.sv
// Falling edge detector for a pin that is synchronous to the core clock.
`timescale 1ns/1ps
module tt_fall_det
  import tt_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // Pin level and detected edge.
  input  wire logic i_level,
  output logic      o_fall
);

  logic prev_q;
  logic prev_d;

  // The previous level starts high so an idle-high pin gives no false edge.
  always_comb begin
    prev_d = i_level;
    o_fall = i_clk_en & prev_q & ~i_level;
  end

  // Registers the previous level.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      prev_q <= 1'b1;
    end else if (i_clk_en) begin
      prev_q <= prev_d;
    end
  end

endmodule

// ===== core/tt_tick_div.sv
// Count tick divider that gives one tick every few enabled clocks.
`timescale 1ns/1ps
module tt_tick_div
  import tt_pkg::*;
(
  // Clock, reset and enable.
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_clk_en,
  // Run request and output tick.
  input  wire logic i_run,
  output logic      o_tick
);

  localparam logic [3:0] DIV_LAST = 4'(TT_BAUD_DIV - 1);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // Counts while running and restarts when stopped, so the first tick is aligned.
  always_comb begin
    cnt_d  = cnt_q;
    o_tick = i_clk_en & i_run & (cnt_q == DIV_LAST);
    if (!i_run) begin
      cnt_d = 4'h0;
    end else if (cnt_q == DIV_LAST) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // Registers the divider count.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_q <= 4'h0;
    end else if (i_clk_en) begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ===== core/tt_timer_two.sv
// Timer two with its flags, external trigger, capture, reload and serial baud select.
// Summary of operation
// - Overflow flag set on rollover or down-match.
// - Overflow flag set only without baud selects.
// - Enabled falling trigger edge sets external flag.
// - Down-count mode toggles external flag, no interrupt.
// - Flag write or trigger edge requests interrupt.
// - Receive baud from this timer or timer one.
// - Receive select forces baud mode, half rate.
// - Transmit baud source chosen likewise, forces baud.
// - Capture on edge, else reload on overflow/edge.
// - Down count when enabled and trigger low.
// - Trigger pin ignored while generating baud rates.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module tt_timer_two
  import tt_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  // AHB-Lite slave.
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Pins and neighbours.
  input  wire logic        i_ext_trigger_pin,
  input  wire logic        i_count_pin,
  input  wire logic        i_t1_overflow,
  input  wire logic [1:0]  i_sp0_mode,
  input  wire logic        i_irq_enable,
  // Results.
  output logic             o_rx_baud_tick,
  output logic             o_tx_baud_tick,
  output logic             o_baud_mode,
  output logic             o_timer_irq
);

  // Control state.
  logic [7:0]    ctrl_q, ctrl_d;
  logic          down_count_enable_q, down_count_enable_d;
  logic [15:0]   count_q, count_d;
  logic [15:0]   reload_q, reload_d;
  // Bus state.
  tt_dphase_type dphase_q, dphase_d;
  logic [7:0]    waddr_q, waddr_d;
  logic [31:0]   hrdata_q, hrdata_d;
  // Output flops.
  logic          rx_tick_q, rx_tick_d;
  logic          tx_tick_q, tx_tick_d;
  logic          baud_q, baud_d;
  logic          irq_q, irq_d;
  // Combinational helpers.
  logic          ext_fall, pin_fall, div_tick, tick;
  logic          baud, cp_eff, toggle_mode, down, ovf_up, unf, roll;
  logic          ext_ok, ext_capture, ext_reload, ext_set;
  logic          addr_ok, take, wr_ctrl, wr_mode, wr_count, wr_reload;

  // Falling edges of the trigger pin and the counter pin.
  tt_fall_det u_ext_fall (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .i_level    (i_ext_trigger_pin),
    .o_fall     (ext_fall)
  );

  tt_fall_det u_pin_fall (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .i_level    (i_count_pin),
    .o_fall     (pin_fall)
  );

  tt_tick_div u_baud_div (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_clk_en   (i_clk_en),
    .i_run      (ctrl_q[TT_BIT_RUN] & baud),
    .o_tick     (div_tick)
  );

  // Bus decode; writes land in the data phase after the address was taken.
  always_comb begin
    addr_ok   = (i_haddr[31:8] == 24'h00_0000) && (i_haddr[1:0] == 2'b00);
    take      = i_hsel && i_hready && i_htrans[TT_HTRANS_ACT];
    dphase_d  = (take && i_hwrite) ? TT_DP_WRITE : TT_DP_IDLE;
    waddr_d   = addr_ok ? i_haddr[7:0] : 8'h00;
    wr_ctrl   = (dphase_q == TT_DP_WRITE) && (waddr_q == TT_CTRL_OFS);
    wr_mode   = (dphase_q == TT_DP_WRITE) && (waddr_q == TT_MODE_OFS);
    wr_count  = (dphase_q == TT_DP_WRITE) && (waddr_q == TT_COUNT_OFS);
    wr_reload = (dphase_q == TT_DP_WRITE) && (waddr_q == TT_RELOAD_OFS);
    hrdata_d  = TT_RDATA_RST;
    if (take && !i_hwrite && addr_ok) begin
      unique case (i_haddr[7:0])
        TT_CTRL_OFS:   hrdata_d = {24'h00_0000, ctrl_q};
        TT_MODE_OFS:   hrdata_d = {31'h0000_0000, down_count_enable_q};
        TT_COUNT_OFS:  hrdata_d = {16'h0000, count_q};
        TT_RELOAD_OFS: hrdata_d = {16'h0000, reload_q};
        default:       hrdata_d = TT_RDATA_RST;
      endcase
    end
  end

  // Mode decode and count events.
  always_comb begin
    baud        = ctrl_q[TT_BIT_RCLK] | ctrl_q[TT_BIT_TX_CLOCK_SELECT];
    cp_eff      = ctrl_q[TT_BIT_CP] & ~baud;
    toggle_mode = ~cp_eff & down_count_enable_q & ~baud;
    down        = toggle_mode & ~i_ext_trigger_pin;
    if (baud) begin
      tick = div_tick;
    end else if (ctrl_q[TT_BIT_CT]) begin
      tick = i_clk_en & ctrl_q[TT_BIT_RUN] & pin_fall;
    end else begin
      tick = i_clk_en & ctrl_q[TT_BIT_RUN];
    end
    ovf_up      = tick & ~down & (count_q == TT_COUNT_TOP);
    unf         = tick & down & (count_q == reload_q);
    roll        = ovf_up | unf;
    ext_ok      = ext_fall & ctrl_q[TT_BIT_EXEN] & ~baud & ~toggle_mode;
    ext_capture = ext_ok & cp_eff;
    ext_reload  = ext_ok & ~cp_eff;
    ext_set     = ext_ok;
  end

  // Next values of the timer registers and flags.
  always_comb begin
    ctrl_d   = ctrl_q;
    down_count_enable_d   = down_count_enable_q;
    count_d  = count_q;
    reload_d = reload_q;
    if (wr_ctrl) begin
      ctrl_d = i_hwdata[7:0];
    end
    if (wr_mode) begin
      down_count_enable_d = i_hwdata[TT_BIT_DOWN_COUNT_ENABLE];
    end
    if (wr_count) begin
      count_d = i_hwdata[15:0];
    end else if (ext_reload) begin
      count_d = reload_q;
    end else if (unf) begin
      count_d = TT_COUNT_TOP;
    end else if (ovf_up) begin
      count_d = cp_eff ? TT_COUNT_RST : reload_q;
    end else if (tick) begin
      count_d = down ? (count_q - TT_COUNT_ONE) : (count_q + TT_COUNT_ONE);
    end
    if (wr_reload) begin
      reload_d = i_hwdata[15:0];
    end else if (ext_capture) begin
      reload_d = count_q;
    end
    // hardware set wins over a clearing write
    if (roll && !baud) begin
      ctrl_d[TT_BIT_OVF] = 1'b1;
    end
    if (toggle_mode && roll) begin
      ctrl_d[TT_BIT_EXT] = ~ctrl_d[TT_BIT_EXT];
    end else if (ext_set) begin
      ctrl_d[TT_BIT_EXT] = 1'b1;
    end
  end

  // Serial timebases, baud mode and interrupt outputs.
  always_comb begin
    rx_tick_d = i_clk_en & i_sp0_mode[0] & (ctrl_q[TT_BIT_RCLK] ? roll : i_t1_overflow);
    tx_tick_d = i_clk_en & i_sp0_mode[0] & (ctrl_q[TT_BIT_TX_CLOCK_SELECT] ? roll : i_t1_overflow);
    baud_d    = baud;
    irq_d     = i_irq_enable & (ctrl_q[TT_BIT_OVF] | (ctrl_q[TT_BIT_EXT] & ~toggle_mode));
  end

  // Registers every group of state.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ctrl_q    <= TT_CTRL_RST;
      down_count_enable_q    <= TT_MODE_RST;
      count_q   <= TT_COUNT_RST;
      reload_q  <= TT_COUNT_RST;
      dphase_q  <= TT_DP_IDLE;
      waddr_q   <= 8'h00;
      hrdata_q  <= TT_RDATA_RST;
      rx_tick_q <= 1'b0;
      tx_tick_q <= 1'b0;
      baud_q    <= 1'b0;
      irq_q     <= 1'b0;
    end else if (i_clk_en) begin
      ctrl_q    <= ctrl_d;
      down_count_enable_q    <= down_count_enable_d;
      count_q   <= count_d;
      reload_q  <= reload_d;
      dphase_q  <= dphase_d;
      waddr_q   <= waddr_d;
      hrdata_q  <= hrdata_d;
      rx_tick_q <= rx_tick_d;
      tx_tick_q <= tx_tick_d;
      baud_q    <= baud_d;
      irq_q     <= irq_d;
    end
  end

  // The slave is always ready and always answers OKAY.
  assign o_hrdata       = hrdata_q;
  assign o_hreadyout    = 1'b1;
  assign o_hresp        = 1'b0;
  assign o_rx_baud_tick = rx_tick_q;
  assign o_tx_baud_tick = tx_tick_q;
  assign o_baud_mode    = baud_q;
  assign o_timer_irq    = irq_q;

  // Checks on the flags, counting and outputs.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  a_ovf_up_set: assert property (i_clk_en && ovf_up && !baud |=> ctrl_q[TT_BIT_OVF])
    else $error("Overflow flag not set on rollover.");
  a_ovf_baud_keep: assert property (i_clk_en && baud && !wr_ctrl |=> $stable(ctrl_q[TT_BIT_OVF]))
    else $error("Overflow flag changed in baud mode.");
  a_ext_edge_set: assert property (i_clk_en && ext_fall && ctrl_q[TT_BIT_EXEN] && !baud && !toggle_mode
    |=> ctrl_q[TT_BIT_EXT])
    else $error("External flag not set by enabled edge.");
  a_ext_toggle_roll: assert property (i_clk_en && toggle_mode && roll && !wr_ctrl
    |=> ctrl_q[TT_BIT_EXT] != $past(ctrl_q[TT_BIT_EXT]))
    else $error("External flag did not toggle on roll.");
  a_irq_ext_flag: assert property (i_clk_en && i_irq_enable && ctrl_q[TT_BIT_EXT] && !toggle_mode
    |=> o_timer_irq)
    else $error("Interrupt missing for external flag.");
  a_irq_toggle_mask: assert property (i_clk_en && toggle_mode && !ctrl_q[TT_BIT_OVF] |=> !o_timer_irq)
    else $error("Interrupt raised by toggling flag.");
  a_rx_source: assert property (i_clk_en && i_sp0_mode[0] && ctrl_q[TT_BIT_RCLK] && roll
    |=> o_rx_baud_tick)
    else $error("Receive tick missing from timer roll.");
  a_tx_source: assert property (i_clk_en && i_sp0_mode[0] && !ctrl_q[TT_BIT_TX_CLOCK_SELECT]
    |=> o_tx_baud_tick == $past(i_t1_overflow))
    else $error("Transmit tick not from timer one.");
  a_baud_half_rate: assert property (tick && baud |=> !tick)
    else $error("Baud ticks on consecutive cycles.");
  a_capture_edge: assert property (i_clk_en && ext_capture && !wr_reload |=> reload_q == $past(count_q))
    else $error("Count not captured on edge.");
  a_down_step: assert property (i_clk_en && tick && down && !unf && !wr_count && !ext_reload
    |=> count_q == $past(count_q) - TT_COUNT_ONE)
    else $error("Count did not step down.");
  a_pin_ignored: assert property (i_clk_en && baud && !wr_count && !tick |=> $stable(count_q))
    else $error("Count moved by pin in baud mode.");

  c_rx_tick: cover property (ctrl_q[TT_BIT_RCLK] && o_rx_baud_tick);
  c_toggle: cover property (toggle_mode && roll);
  c_capture: cover property (ext_capture);
  c_irq: cover property (o_timer_irq);

endmodule

// ===== bench/tt_far_side.sv
// Model of the trigger pin, timer one and the serial port tick counter.
`timescale 1ns/1ps
module tt_far_side (
  // Clock and reset.
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  // Baud ticks from the timer.
  input  wire logic i_rx_tick,
  input  wire logic i_tx_tick,
  // Pin and neighbour outputs.
  output logic      o_pin,
  output logic      o_t1_ovf
);
  int         rx_ticks = 0;
  int         tx_ticks = 0;
  logic [3:0] div_q    = 4'h0;
  initial o_pin = 1'b1;
  initial o_t1_ovf = 1'b0;
  // Timer one overflows once every sixteen clocks.
  always @(posedge i_core_clk) begin
    div_q    <= i_sys_rst ? 4'h0 : div_q + 4'h1;
    o_t1_ovf <= !i_sys_rst && (div_q == 4'hF);
  end
  // Serial port zero counts each baud tick it is given.
  always @(posedge i_core_clk) begin
    rx_ticks <= i_sys_rst ? 0 : rx_ticks + int'(i_rx_tick);
    tx_ticks <= i_sys_rst ? 0 : tx_ticks + int'(i_tx_tick);
  end
  // Pin changes only just after a clock edge.
  task automatic set_pin(input logic v);
    @(posedge i_core_clk);
    o_pin <= v;
  endtask
  // A short low pulse gives one falling edge.
  task automatic pulse_low();
    set_pin(1'b0);
    repeat (2) @(posedge i_core_clk);
    set_pin(1'b1);
  endtask
endmodule

// ===== bench/tt_timer_two_test.sv
// Bench for the timer-two block driven through its register bus.
`timescale 1ns/1ps
module tt_timer_two_test;
  import tt_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hready;
  logic        irq_en = 1'b1;
  logic        clk_en = 1'b1;
  logic        hsel = 1'b1;
  logic [1:0]  sp0_mode = 2'h1;
  logic        hresp;
  logic        pin, t1_ovf, rx_tick, tx_tick, baud_mode, irq;
  logic [31:0] rdata;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          snap;
  // Clock of 100 MHz.
  always #5 clk = ~clk;
  tt_timer_two dut_u (.i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(clk_en), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_ext_trigger_pin(pin), .i_count_pin(1'b1), .i_t1_overflow(t1_ovf), .i_sp0_mode(sp0_mode),
    .i_irq_enable(irq_en), .o_rx_baud_tick(rx_tick), .o_tx_baud_tick(tx_tick),
    .o_baud_mode(baud_mode), .o_timer_irq(irq));
  tt_far_side far_u (.i_core_clk(clk), .i_sys_rst(rst), .i_rx_tick(rx_tick),
    .i_tx_tick(tx_tick), .o_pin(pin), .o_t1_ovf(t1_ovf));
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One compare of a value against its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data lands in rdata.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
  // Main sequence of scenarios.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    wr(TT_COUNT_OFS, 32'h0000_1234);
    wr(TT_CTRL_OFS, 32'h0000_0009);
    far_u.pulse_low();
    repeat (3) @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_0049);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(TT_RELOAD_OFS, 32'h0000_1234);
    wr(TT_CTRL_OFS, 32'h0000_0001);
    far_u.pulse_low();
    repeat (3) @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(TT_RELOAD_OFS, 32'h0000_0100);
    wr(TT_COUNT_OFS, 32'h0000_FFFF);
    wr(TT_CTRL_OFS, 32'h0000_0004);
    repeat (4) @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_0084);
    chk({31'h0, irq}, 32'h0000_0001);
    xfer(1'b0, TT_COUNT_OFS, 32'h0000_0000);
    chk({31'h0, rdata > 32'h0000_0100 && rdata < 32'h0000_0120}, 32'h0000_0001);
    wr(TT_CTRL_OFS, 32'h0000_0000);
    wr(TT_MODE_OFS, 32'h0000_0001);
    far_u.set_pin(1'b0);
    wr(TT_COUNT_OFS, 32'h0000_0110);
    wr(TT_CTRL_OFS, 32'h0000_0004);
    repeat (8) @(posedge clk);
    wr(TT_CTRL_OFS, 32'h0000_0000);
    xfer(1'b0, TT_COUNT_OFS, 32'h0000_0000);
    chk({31'h0, rdata < 32'h0000_0110 && rdata > 32'h0000_0100}, 32'h0000_0001);
    far_u.set_pin(1'b1);
    wr(TT_COUNT_OFS, 32'h0000_FFFF);
    wr(TT_CTRL_OFS, 32'h0000_0004);
    repeat (4) @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_00C4);
    wr(TT_CTRL_OFS, 32'h0000_0040);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(TT_MODE_OFS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(TT_CTRL_OFS, 32'h0000_0000);
    wr(TT_CTRL_OFS, 32'h0000_0040);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(TT_CTRL_OFS, 32'h0000_0000);
    snap = far_u.rx_ticks;
    repeat (40) @(posedge clk);
    chk({31'h0, far_u.rx_ticks > snap}, 32'h0000_0001);
    wr(TT_CTRL_OFS, 32'h0000_0020);
    repeat (2) @(posedge clk);
    snap = far_u.rx_ticks;
    repeat (40) @(posedge clk);
    chk({31'h0, far_u.rx_ticks == snap}, 32'h0000_0001);
    wr(TT_COUNT_OFS, 32'h0000_FFFF);
    wr(TT_CTRL_OFS, 32'h0000_002C);
    repeat (8) @(posedge clk);
    chk({31'h0, far_u.rx_ticks > snap}, 32'h0000_0001);
    chk({31'h0, baud_mode}, 32'h0000_0001);
    rd_chk(TT_CTRL_OFS, 32'h0000_002C);
    far_u.pulse_low();
    repeat (3) @(posedge clk);
    rd_chk(TT_CTRL_OFS, 32'h0000_002C);
    wr(TT_CTRL_OFS, 32'h0000_0000);
    wr(TT_COUNT_OFS, 32'h0000_FFFF);
    snap = far_u.tx_ticks;
    wr(TT_CTRL_OFS, 32'h0000_0014);
    repeat (8) @(posedge clk);
    chk({31'h0, far_u.tx_ticks > snap}, 32'h0000_0001);
    chk({31'h0, hresp}, 32'h0000_0000);
    // Serial modes without the baud bit get no timebase ticks.
    sp0_mode <= 2'h0;
    @(posedge clk);
    snap = far_u.tx_ticks;
    repeat (40) @(posedge clk);
    chk({31'h0, far_u.tx_ticks == snap}, 32'h0000_0001);
    sp0_mode <= 2'h1;
    // A low clock enable freezes the running count.
    xfer(1'b0, TT_COUNT_OFS, 32'h0000_0000);
    snap = int'(rdata);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b1;
    xfer(1'b0, TT_COUNT_OFS, 32'h0000_0000);
    chk({31'h0, (int'(rdata) - snap) < 8}, 32'h0000_0001);
    report_and_stop();
  end
endmodule
